// ---- design/act_regs.svh ----
`ifndef ACT_REGS_SVH
`define ACT_REGS_SVH

// ----------------------------------------
// Pointer byte layout and codes
// ----------------------------------------
`define ACT_CMD_MSB 7
`define ACT_CMD_LSB 4
`define ACT_PTR_MSB 3
`define ACT_PTR_LSB 0
`define ACT_CMD_OFF 4'h0
`define ACT_CMD_SEQ 4'h7
`define ACT_CMD_SINGLE_BIT 3
`define ACT_PTR_RESULT 4'h0
`define ACT_HS_MASTER_CODE 5'h01
// Arbitrary bus address
`define ACT_DEV_ADDR 7'h23

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACT_CLK_MHZ 100
`define ACT_PWRUP_NS 1000
`define ACT_CONV_NS 2000
`define ACT_CMD_TOTAL_NS 3000
`define ACT_PWRUP_CYC ((`ACT_PWRUP_NS * `ACT_CLK_MHZ + 999) / 1000)
`define ACT_CONV_CYC ((`ACT_CONV_NS * `ACT_CLK_MHZ + 999) / 1000)
`define ACT_CMD_WAKE_CYC (((`ACT_CMD_TOTAL_NS - `ACT_CONV_NS) * `ACT_CLK_MHZ + 999) / 1000)

`endif

// ---- design/act_pkg.sv ----
package act_pkg;

   typedef enum logic [1:0] {ACT_SHUTDOWN, ACT_POWERUP, ACT_CONVERT} act_state_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic cmd_edge;
      logic [3:0] cmd;
      logic ptr_done;
      logic [3:0] ptr;
      logic rd_ack_clk;
      logic nack;
      logic rd_pair;
      logic hs;
   } act_bus_evt_t;

endpackage : act_pkg

// ---- design/act_bus_watch.sv ----
`timescale 1ns/1ns
`include "act_regs.svh"

module act_bus_watch #(
   parameter logic [6:0] DEV_ADDR = `ACT_DEV_ADDR
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output act_pkg::act_bus_evt_t evt_out
);

   logic scl_q, scl_d, sda_q, sda_d;
   logic [3:0] bitn_q, bitn_d, byte_q, byte_d;
   logic [7:0] sh_q, sh_d;
   logic ack_q, ack_d, match_q, match_d, rd_q, rd_d, hs_q, hs_d;
   act_pkg::act_bus_evt_t evt_q, evt_d;

   // ----------------------------------------
   // Bit and byte tracking
   // ----------------------------------------
   always_comb
   begin
      scl_d = scl_in;
      sda_d = sda_in;
      bitn_d = bitn_q;
      byte_d = byte_q;
      sh_d = sh_q;
      ack_d = ack_q;
      match_d = match_q;
      rd_d = rd_q;
      hs_d = hs_q;
      evt_d = '0;
      evt_d.hs = hs_q;
      if (scl_in && scl_q && sda_q && !sda_in)
      begin
         bitn_d = 4'h0;
         byte_d = 4'h0;
         match_d = 1'b0;
         rd_d = 1'b0;
         evt_d.start = 1'b1;
      end
      else if (scl_in && scl_q && !sda_q && sda_in)
      begin
         // High speed lasts until stop
         match_d = 1'b0;
         hs_d = 1'b0;
         evt_d.stop = 1'b1;
      end
      else if (scl_in && !scl_q)
      begin
         if (bitn_q < 4'h8)
            sh_d = {sh_q[6:0], sda_in};
         else
            ack_d = sda_in;
         if (bitn_q < 4'h9)
            bitn_d = bitn_q + 4'h1;
      end
      else if (!scl_in && scl_q)
      begin
         // Fifth falling edge of the pointer byte: command nibble complete
         if (bitn_q == 4'h5 && byte_q == 4'h1 && match_q && !rd_q)
         begin
            evt_d.cmd_edge = 1'b1;
            evt_d.cmd = sh_q[4:1];
         end
         if (bitn_q == 4'h8 && byte_q == 4'h0)
         begin
            match_d = (sh_q[7:1] == DEV_ADDR);
            rd_d = sh_q[0];
            if (sh_q[7:3] == `ACT_HS_MASTER_CODE)
               hs_d = 1'b1;
            evt_d.rd_ack_clk = (sh_q[7:1] == DEV_ADDR) && sh_q[0];
         end
         else if (bitn_q == 4'h8 && byte_q == 4'h1 && match_q && !rd_q)
         begin
            evt_d.ptr_done = 1'b1;
            evt_d.cmd = sh_q[`ACT_CMD_MSB:`ACT_CMD_LSB];
            evt_d.ptr = sh_q[`ACT_PTR_MSB:`ACT_PTR_LSB];
         end
         if (bitn_q == 4'h9)
         begin
            bitn_d = 4'h0;
            byte_d = (byte_q == 4'hF) ? 4'h2 : byte_q + 4'h1;
            if (match_q && rd_q && byte_q != 4'h0)
            begin
               if (ack_q)
                  evt_d.nack = 1'b1;
               else if (!byte_q[0])
                  evt_d.rd_pair = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bitn_q <= 4'h0;
         byte_q <= 4'h0;
         sh_q <= 8'h00;
         ack_q <= 1'b1;
         match_q <= 1'b0;
         rd_q <= 1'b0;
         hs_q <= 1'b0;
         evt_q <= '0;
      end
      else if (ce_in)
      begin
         scl_q <= scl_d;
         sda_q <= sda_d;
         bitn_q <= bitn_d;
         byte_q <= byte_d;
         sh_q <= sh_d;
         ack_q <= ack_d;
         match_q <= match_d;
         rd_q <= rd_d;
         hs_q <= hs_d;
         evt_q <= evt_d;
      end
   end

   assign evt_out = evt_q;

endmodule : act_bus_watch

// ---- design/act_trigger_ctrl.sv ----
// What this block does
// RL1: Conversions are timed from the internal clock; serial clock only for transfers.
// RL2: Pin mode: controller holds start pin high at least 1 us.
// RL3: Start pin falling edge puts sampler in hold and starts conversion.
// RL4: Pin conversion ends about 2 us later, then shutdown until next rise.
// RL5: Pulse of 1 us or less still converts, result flagged invalid.
// RL6: Controller should keep the serial bus quiet during pin conversions.
// RL7: Pin mode needs zero command bits; other modes keep the pin low.
// RL8: Controller points at the result register before reading a result.
// RL9: Pin mode channel or channel sequence comes from configuration channel bits.
// RL10: Controller may hold serial clock high while pulsing, then 18 clocks read.
// RL11: Non-zero command field starts a conversion; zero leaves command mode unused. Here only 1xxx and 0111 with channel bits set start one; 0001-0110 none.
// RL12: Command top bit set selects channel equal to low three bits.
// RL13: Command 0111 converts selected channels lowest to highest until done.
// RL14: Stop condition or master not-acknowledge aborts command-mode converting.
// RL15: Power-up begins at fifth falling serial clock edge of pointer byte.
// RL16: Command-mode wake, acquisition and conversion take about 3 us.
// RL17: Controller re-addresses for read; read returns commanded channel result.
// RL18: In a sequence each two-byte read returns one result while next converts.
// RL19: High speed read during conversion: hold serial clock low in ack clock.
// RL20: Command written with zero pointer field makes next read hit result register.
// RL21: Durations are parameter counts; cut-short power-up flags the result invalid.
`timescale 1ns/1ns
`include "act_regs.svh"

module act_trigger_ctrl #(
   parameter logic [6:0] DEV_ADDR = `ACT_DEV_ADDR,
   parameter int unsigned PWRUP_CYC = `ACT_PWRUP_CYC,
   parameter int unsigned CONV_CYC = `ACT_CONV_CYC,
   parameter int unsigned CMD_WAKE_CYC = `ACT_CMD_WAKE_CYC
) (
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic CONVERT_START_PIN_IN,
   input wire logic SCL_IN,
   input wire logic SDA_IN,
   input wire logic [7:0] CHANNEL_SELECT_BITS_IN,
   output logic SCL_OUT,
   output logic SCL_OE_OUT,
   output logic POWERED_OUT,
   output logic HOLD_OUT,
   output logic BUSY_OUT,
   output logic [2:0] CHANNEL_OUT,
   output logic DONE_OUT,
   output logic RESULT_INVALID_OUT,
   output logic [3:0] POINTER_FIELD_OUT,
   output logic RESULT_SELECTED_OUT
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [2:0] async_in;
   logic [2:0] meta_q;
   logic [2:0] sync_q;
   logic pin_q;

   assign async_in = {CONVERT_START_PIN_IN, SCL_IN, SDA_IN};

   for (genvar i = 0; i < 3; i++)
   begin : g_sync
      always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
      begin
         if (!RST_N_IN)
         begin
            meta_q[i] <= (i == 2) ? 1'b0 : 1'b1;
            sync_q[i] <= (i == 2) ? 1'b0 : 1'b1;
         end
         else if (CE_IN)
         begin
            meta_q[i] <= async_in[i];
            sync_q[i] <= meta_q[i];
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         pin_q <= 1'b0;
      else if (CE_IN)
         pin_q <= sync_q[2];
   end

   logic pin_rise, pin_fall;
   assign pin_rise = sync_q[2] && !pin_q;
   assign pin_fall = !sync_q[2] && pin_q;

   act_pkg::act_bus_evt_t evt;

   act_bus_watch #(
      .DEV_ADDR(DEV_ADDR)
   ) u_watch (
      .clk_in(CLK_SYS_IN),
      .rst_n_in(RST_N_IN),
      .ce_in(CE_IN),
      .scl_in(sync_q[1]),
      .sda_in(sync_q[0]),
      .evt_out(evt)
   );

   // Lowest set channel above cur, wrapping to the lowest set one
   function automatic logic [2:0] next_chan(input logic [7:0] mask, input logic [2:0] cur);
      logic [2:0] res;
      logic found;
      res = cur;
      found = 1'b0;
      for (int k = 7; k >= 0; k--)
      begin
         if (mask[k] && 3'(k) > cur)
         begin
            res = 3'(k);
            found = 1'b1;
         end
      end
      if (!found)
      begin
         for (int k = 7; k >= 0; k--)
         begin
            if (mask[k])
               res = 3'(k);
         end
      end
      return res;
   endfunction : next_chan

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   act_pkg::act_state_t state_q, state_d;
   logic [11:0] cnt_q, cnt_d;
   logic cmd_mode_q, cmd_mode_d;
   logic [7:0] seq_q, seq_d;
   logic pend_q, pend_d;
   logic [2:0] chan_q, chan_d, pin_chan_q, pin_chan_d;
   logic invalid_q, invalid_d, done_q, done_d, stretch_q, stretch_d;
   logic [3:0] ptr_q, ptr_d;
   logic [7:0] seq_left;

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      cmd_mode_d = cmd_mode_q;
      seq_d = seq_q;
      pend_d = pend_q;
      chan_d = chan_q;
      pin_chan_d = pin_chan_q;
      invalid_d = invalid_q;
      done_d = 1'b0;
      stretch_d = stretch_q;
      ptr_d = ptr_q;
      seq_left = seq_q;
      seq_left[chan_q] = 1'b0;
      if (evt.ptr_done)
         ptr_d = evt.ptr; // [RL20]
      // Stop or not-acknowledge ends command work in any state
      if (cmd_mode_q && (evt.stop || evt.nack))
      begin
         state_d = act_pkg::ACT_SHUTDOWN; // [RL14]
         pend_d = 1'b0;
         seq_d = 8'h00;
         cnt_d = 12'h000;
      end
      else
      begin
         case (state_q)
            act_pkg::ACT_SHUTDOWN:
            begin
               cnt_d = 12'h000;
               if (pin_rise)
               begin
                  state_d = act_pkg::ACT_POWERUP; // [RL4]
                  cmd_mode_d = 1'b0;
                  pend_d = 1'b0;
                  chan_d = CHANNEL_SELECT_BITS_IN[pin_chan_q] ? pin_chan_q
                     : next_chan(CHANNEL_SELECT_BITS_IN, pin_chan_q); // [RL9]
               end
               else if (evt.cmd_edge && evt.cmd != `ACT_CMD_OFF) // [RL11] [RL15]
               begin
                  cmd_mode_d = 1'b1;
                  pend_d = 1'b0;
                  if (evt.cmd[`ACT_CMD_SINGLE_BIT])
                  begin
                     state_d = act_pkg::ACT_POWERUP;
                     seq_d = 8'h00;
                     chan_d = evt.cmd[2:0]; // [RL12]
                  end
                  else if (evt.cmd == `ACT_CMD_SEQ && CHANNEL_SELECT_BITS_IN != 8'h00)
                  begin
                     state_d = act_pkg::ACT_POWERUP;
                     seq_d = CHANNEL_SELECT_BITS_IN; // [RL13]
                     chan_d = next_chan(CHANNEL_SELECT_BITS_IN, 3'h7);
                  end
               end
               else if (pend_q && evt.rd_pair)
               begin
                  // Next channel converts once its predecessor has been read out as a byte pair
                  state_d = act_pkg::ACT_POWERUP; // [RL18]
                  pend_d = 1'b0;
                  chan_d = next_chan(seq_q, 3'h7); // [RL13]
               end
            end
            act_pkg::ACT_POWERUP:
            begin
               if (cnt_q != 12'hFFF)
                  cnt_d = cnt_q + 12'h001;
               if (!cmd_mode_q && pin_fall)
               begin
                  state_d = act_pkg::ACT_CONVERT; // [RL3]
                  invalid_d = (cnt_q < 12'(PWRUP_CYC)); // [RL5] [RL21]
                  cnt_d = 12'h000;
               end
               else if (cmd_mode_q && cnt_q >= 12'(CMD_WAKE_CYC - 1))
               begin
                  state_d = act_pkg::ACT_CONVERT; // [RL16]
                  invalid_d = 1'b0;
                  cnt_d = 12'h000;
               end
            end
            act_pkg::ACT_CONVERT:
            begin
               cnt_d = cnt_q + 12'h001;
               // Internal clock only; serial clock plays no part in timing
               if (cnt_q >= 12'(CONV_CYC - 1)) // [RL1] [RL21]
               begin
                  state_d = act_pkg::ACT_SHUTDOWN; // [RL4] [RL16]
                  cnt_d = 12'h000;
                  done_d = 1'b1;
                  if (!cmd_mode_q)
                     pin_chan_d = next_chan(CHANNEL_SELECT_BITS_IN, chan_q); // [RL9]
                  else
                  begin
                     seq_d = seq_left;
                     pend_d = (seq_left != 8'h00); // [RL13]
                  end
               end
            end
            default:
            begin
               state_d = act_pkg::ACT_SHUTDOWN;
               cnt_d = 12'h000;
            end
         endcase
      end
      // Stretch only in high speed, only while a command conversion runs
      // Not when the conversion ends in this cycle, or the stretch would outlive it
      if (evt.rd_ack_clk && evt.hs && cmd_mode_q && state_q != act_pkg::ACT_SHUTDOWN
         && state_d != act_pkg::ACT_SHUTDOWN)
         stretch_d = 1'b1; // [RL19]
      else if (state_d == act_pkg::ACT_SHUTDOWN || evt.stop)
         stretch_d = 1'b0; // [RL19]
   end

   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         state_q <= act_pkg::ACT_SHUTDOWN;
         cnt_q <= 12'h000;
         cmd_mode_q <= 1'b0;
         seq_q <= 8'h00;
         pend_q <= 1'b0;
         chan_q <= 3'h0;
         pin_chan_q <= 3'h0;
         invalid_q <= 1'b0;
         done_q <= 1'b0;
         stretch_q <= 1'b0;
         ptr_q <= `ACT_PTR_RESULT;
      end
      else if (CE_IN)
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cmd_mode_q <= cmd_mode_d;
         seq_q <= seq_d;
         pend_q <= pend_d;
         chan_q <= chan_d;
         pin_chan_q <= pin_chan_d;
         invalid_q <= invalid_d;
         done_q <= done_d;
         stretch_q <= stretch_d;
         ptr_q <= ptr_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign SCL_OUT = 1'b0;
   assign SCL_OE_OUT = stretch_q;
   assign POWERED_OUT = (state_q != act_pkg::ACT_SHUTDOWN);
   assign HOLD_OUT = (state_q == act_pkg::ACT_CONVERT); // [RL3]
   assign BUSY_OUT = (state_q != act_pkg::ACT_SHUTDOWN);
   assign CHANNEL_OUT = chan_q;
   assign DONE_OUT = done_q;
   assign RESULT_INVALID_OUT = invalid_q;
   assign POINTER_FIELD_OUT = ptr_q;
   assign RESULT_SELECTED_OUT = (ptr_q == `ACT_PTR_RESULT); // [RL20]

endmodule : act_trigger_ctrl

// ---- dv/act_chk.sv ----
`timescale 1ns/1ns
module act_chk #(
   parameter int unsigned CONV_CYC = 200
) (
   input wire logic CLK_SYS_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic CONVERT_START_PIN_IN,
   input wire logic SCL_OUT,
   input wire logic SCL_OE_OUT,
   input wire logic POWERED_OUT,
   input wire logic HOLD_OUT,
   input wire logic BUSY_OUT,
   input wire logic DONE_OUT,
   input wire logic [3:0] POINTER_FIELD_OUT,
   input wire logic RESULT_SELECTED_OUT
);
   int unsigned hold_cnt_q;
   int unsigned hold_cnt_d;
   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (!RST_N_IN);
   // ----
   // Hold length
   // ----
   // Frozen cycles do not count, the design stands still with the enable low
   always_comb hold_cnt_d = !HOLD_OUT ? 0 : (CE_IN ? hold_cnt_q + 1 : hold_cnt_q);
   always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         hold_cnt_q <= 0;
      else
         hold_cnt_q <= hold_cnt_d;
   end
   sequence s_pin_rise;
      $rose(CONVERT_START_PIN_IN) && !POWERED_OUT;
   endsequence
   sequence s_pin_fall;
      $fell(CONVERT_START_PIN_IN) && POWERED_OUT && !HOLD_OUT;
   endsequence
   property p_done_len;
      DONE_OUT |-> hold_cnt_q == CONV_CYC && !HOLD_OUT;
   endproperty
   property p_done_pulse;
      DONE_OUT |=> !DONE_OUT && !POWERED_OUT;
   endproperty
   property p_pin_rise;
      s_pin_rise |-> ##[2:4] POWERED_OUT;
   endproperty
   property p_pin_fall;
      s_pin_fall |-> ##[2:6] HOLD_OUT;
   endproperty
   property p_hold_pwr;
      HOLD_OUT |-> POWERED_OUT && BUSY_OUT;
   endproperty
   property p_stretch;
      SCL_OE_OUT |-> BUSY_OUT && !SCL_OUT;
   endproperty
   property p_stretch_end;
      $fell(BUSY_OUT) |-> !SCL_OE_OUT;
   endproperty
   property p_sel;
      RESULT_SELECTED_OUT == (POINTER_FIELD_OUT == 4'h0);
   endproperty
   a_done_len: assert property (p_done_len) else $error("conversion length wrong");
   a_done_pulse: assert property (p_done_pulse) else $error("done not single or still powered");
   a_pin_rise: assert property (p_pin_rise) else $error("no power up on pin rise");
   a_pin_fall: assert property (p_pin_fall) else $error("no hold after pin fall");
   a_hold_pwr: assert property (p_hold_pwr) else $error("hold while unpowered");
   a_stretch: assert property (p_stretch) else $error("stretch while idle");
   a_stretch_end: assert property (p_stretch_end) else $error("stretch kept after conversion");
   a_sel: assert property (p_sel) else $error("result select wrong");
endmodule : act_chk

bind act_trigger_ctrl act_chk #(.CONV_CYC(CONV_CYC)) u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN),
   .CE_IN(CE_IN), .CONVERT_START_PIN_IN(CONVERT_START_PIN_IN), .SCL_OUT(SCL_OUT), .SCL_OE_OUT(SCL_OE_OUT),
   .POWERED_OUT(POWERED_OUT), .HOLD_OUT(HOLD_OUT), .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT),
   .POINTER_FIELD_OUT(POINTER_FIELD_OUT), .RESULT_SELECTED_OUT(RESULT_SELECTED_OUT));

// ---- dv/act_master.sv ----
`timescale 1ns/1ns
module act_master (
   input wire logic clk_in,
   input wire logic scl_in,
   output logic scl_out,
   output logic sda_out,
   output logic pin_out
);
   // SDA high means released; the line has a pull-up
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
      pin_out = 1'b0;
   end
   task automatic tk(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tk
   // Bounded wait so a stuck stretch cannot hang the run
   task automatic bt(input logic b);
      int n;
      sda_out = b;
      tk(2);
      scl_out = 1'b1;
      n = 0;
      while (scl_in !== 1'b1 && n < 1000)
      begin
         tk(1);
         n++;
      end
      tk(8);
      scl_out = 1'b0;
      tk(6);
   endtask : bt
   task automatic start();
      sda_out = 1'b1;
      tk(4);
      scl_out = 1'b1;
      tk(4);
      sda_out = 1'b0;
      tk(4);
      scl_out = 1'b0;
      tk(4);
   endtask : start
   task automatic stop();
      sda_out = 1'b0;
      tk(4);
      scl_out = 1'b1;
      tk(4);
      sda_out = 1'b1;
      tk(4);
   endtask : stop
   task automatic wb(input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         bt(v[i]);
      bt(1'b1);
   endtask : wb
   task automatic rd(input logic nack);
      repeat (8) bt(1'b1);
      bt(nack);
   endtask : rd
   // Bus stays idle with SCL high during the pulse
   task automatic pulse(input int n);
      pin_out = 1'b1;
      tk(n);
      pin_out = 1'b0;
   endtask : pulse
endmodule : act_master

// ---- dv/tb_top.sv ----
`timescale 1ns/1ns
`include "act_regs.svh"
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] bits = 8'h00;
   logic scl_m, sda_m, pin, scl_w, scl_o, scl_oe, pwr, hold, busy, done, inv, sel;
   logic [2:0] chan;
   logic [3:0] ptr;
   logic saw_oe = 1'b0;
   logic ce = 1'b1;
   int n_errors = 0;
   int checked = 0;
   int n_done = 0;
   int cyc = 0;
   int d0;
   // cmd, channel bits, starts, channel
   logic [15:0] rows [12] = '{16'h8008, 16'h9009, 16'hA00A, 16'hB00B, 16'hC00C, 16'hD00D,
      16'hE00E, 16'hF00F, 16'h0FF0, 16'h3FF0, 16'h7000, 16'h720D};
   always #5 clk = ~clk;
   assign scl_w = scl_m & ~(scl_oe & ~scl_o);
   act_master u_mst (.clk_in(clk), .scl_in(scl_w), .scl_out(scl_m), .sda_out(sda_m), .pin_out(pin));
   act_trigger_ctrl dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .CONVERT_START_PIN_IN(pin),
      .SCL_IN(scl_w), .SDA_IN(sda_m), .CHANNEL_SELECT_BITS_IN(bits), .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe),
      .POWERED_OUT(pwr), .HOLD_OUT(hold), .BUSY_OUT(busy), .CHANNEL_OUT(chan), .DONE_OUT(done),
      .RESULT_INVALID_OUT(inv), .POINTER_FIELD_OUT(ptr), .RESULT_SELECTED_OUT(sel));
   always @(negedge clk)
   begin
      cyc++;
      if (done === 1'b1)
         n_done++;
      if (scl_oe === 1'b1)
         saw_oe = 1'b1;
      if (cyc == 60000)
      begin
         n_errors++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         $display("FAIL %s exp %0h got %0h", nm, e, g);
         n_errors++;
      end
   endtask : chk
   task automatic wdone(input int m);
      int n;
      n = 0;
      while (done !== 1'b1 && n < m)
      begin
         u_mst.tk(1);
         n++;
      end
      u_mst.tk(1);
   endtask : wdone
   task automatic wp(input logic [7:0] pb);
      u_mst.start();
      u_mst.wb({`ACT_DEV_ADDR, 1'b0});
      u_mst.wb(pb);
   endtask : wp
   task automatic rda();
      u_mst.start();
      u_mst.wb({`ACT_DEV_ADDR, 1'b1});
   endtask : rda
   task automatic final_report();
      $display("checked %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      u_mst.tk(2);
      wp(8'h05);
      u_mst.stop();
      chk("ptr", 8'h05, 8'(ptr));
      chk("sel", 8'h00, 8'(sel));
      $display("end pointer");
      foreach (rows[i])
      begin
         bits = rows[i][11:4];
         d0 = n_done;
         wp({rows[i][15:12], 4'h0});
         wdone(400);
         u_mst.stop();
         chk("cnt", 8'(rows[i][3]), 8'(n_done - d0));
         if (rows[i][3])
            chk("chan", 8'(rows[i][2:0]), 8'(chan));
         chk("sel", 8'h01, 8'(sel));
      end
      $display("end rows");
      bits = 8'h05;
      u_mst.pulse(120);
      wdone(300);
      chk("chan", 8'h00, 8'(chan));
      chk("inv", 8'h00, 8'(inv));
      u_mst.tk(50);
      chk("pwr", 8'h00, 8'(pwr));
      u_mst.pulse(120);
      wdone(300);
      chk("chan", 8'h02, 8'(chan));
      u_mst.pulse(10);
      wdone(300);
      chk("inv", 8'h01, 8'(inv));
      chk("chan", 8'h00, 8'(chan));
      $display("end pin");
      // Enable low for 30 cycles mid-conversion pushes the end out by as much
      d0 = n_done;
      u_mst.pulse(120);
      u_mst.tk(20);
      ce = 1'b0;
      u_mst.tk(30);
      chk("hold", 8'h01, 8'(hold));
      chk("busy", 8'h01, 8'(busy));
      ce = 1'b1;
      u_mst.tk(170);
      chk("cnt", 8'h00, 8'(n_done - d0));
      wdone(100);
      chk("cnt", 8'h01, 8'(n_done - d0));
      chk("busy", 8'h00, 8'(busy));
      $display("end enable");
      bits = 8'h03;
      d0 = n_done;
      wp(8'h70);
      wdone(400);
      chk("chan", 8'h00, 8'(chan));
      rda();
      u_mst.rd(1'b0);
      u_mst.rd(1'b0);
      wdone(400);
      chk("chan", 8'h01, 8'(chan));
      u_mst.rd(1'b0);
      u_mst.rd(1'b1);
      u_mst.stop();
      chk("cnt", 8'h02, 8'(n_done - d0));
      $display("end sequence");
      d0 = n_done;
      wp(8'h70);
      wdone(400);
      rda();
      u_mst.rd(1'b0);
      u_mst.rd(1'b0);
      u_mst.stop();
      u_mst.tk(400);
      chk("cnt", 8'h01, 8'(n_done - d0));
      chk("pwr", 8'h00, 8'(pwr));
      $display("end abort");
      d0 = n_done;
      saw_oe = 1'b0;
      u_mst.start();
      u_mst.wb(8'h09);
      wp(8'h80);
      rda();
      u_mst.rd(1'b1);
      u_mst.stop();
      chk("oe_seen", 8'h01, 8'(saw_oe));
      chk("oe", 8'h00, 8'(scl_oe));
      chk("cnt", 8'h01, 8'(n_done - d0));
      $display("end stretch");
      wp(8'h05);
      u_mst.stop();
      u_mst.pulse(120);
      u_mst.tk(20);
      rst_n = 1'b0;
      u_mst.tk(1);
      chk("hold", 8'h00, 8'(hold));
      chk("ptr", 8'h00, 8'(ptr));
      chk("sel", 8'h01, 8'(sel));
      u_mst.tk(5);
      rst_n = 1'b1;
      u_mst.tk(300);
      chk("pwr", 8'h00, 8'(pwr));
      $display("end reset");
      final_report();
   end
endmodule : tb_top
